/* File: irig_timecode_frame_encoder.v */
// serial timecode frame encoder with a classic wishbone register port.
// assumes epoch_i is a one-cycle pulse at each on-time second boundary.
//
// Operation
// - software selects one of five frame formats
// - format resets to the B122 variant
// - B122 elements run at 100 per second
// - B122 carries seconds through day-of-year in BCD
// - B123 adds 17-bit binary seconds from element 80
// - B120 fills control area; markers 59,69,79
// - year units at 50-53, tens 55-58
// - element 60 flags leap second pending
// - element 61 high means leap delete
// - element 62 dst pending, 63 dst active
// - offset sign at 64, hours 65-68
// - element 70 flags extra half hour offset
// - quality code in 71-74, lsb first
// - quality code from estimated time error bands
// - element 75 gives odd parity of prior bits
// - long format sends 100 elements, seconds to days
// - short format sends 25 elements, seconds to hours
// - level-shift output beside the modulated one
`timescale 1ns/1ps
`include "irig_tc_defines.vh"
module irig_timecode_frame_encoder #(
  parameter CNT_W = 24,
  parameter ELEM_CYC_FAST = `TC_ELEM_CYC_FAST,
  parameter ELEM_CYC_SLOW = `TC_ELEM_CYC_SLOW
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire epoch_i,
  input wire gps_locked_once_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg dc_level_shift_o,
  output reg modulated_timecode_output_o,
  output reg frame_active_o
);

////////////////////////////////////////////////////////////////////////////
// registers
reg [31:0] ctrl_r;
reg [31:0] time0_r;
reg [31:0] time1_r;
reg [31:0] stcfg_r;
reg [31:0] errns_r;
reg [2:0] fmt_r;
reg [99:0] frame_r;
reg [6:0] idx_r;
reg [15:0] frame_cnt_r;
reg [2:0] state_r;
reg [2:0] state_nxt;
reg [99:0] frame_nxt;
reg [3:0] quality;
reg [1:0] sym;
reg [31:0] rd_val;
reg [31:0] high_wide;
reg [31:0] period_wide;

localparam ST_IDLE = 3'b001;
localparam ST_RUN = 3'b010;
localparam ST_WAIT = 3'b100;

wire req;
wire enable;
wire epoch;
wire elem_end;
wire shp_level;
wire shp_active;
wire short_fmt;
wire [6:0] last_idx;
wire [6:0] sel_idx;
wire [2:0] fmt_wr;
wire more;
wire [99:0] mark_long;
wire [99:0] mark_short;

assign req = cyc_i && stb_i && !ack_o;
assign enable = ctrl_r[`TC_CTRL_EN_BIT];
assign epoch = epoch_i && enable;
assign fmt_wr = ctrl_r[`TC_CTRL_FMT_LSB+2:`TC_CTRL_FMT_LSB];
assign short_fmt = (fmt_r == `TC_FMT_2137);
assign last_idx = short_fmt ? `TC_LAST_SHORT : `TC_LAST_LONG;
assign more = (state_r == ST_RUN) && (idx_r != last_idx);
// element 0 is always the reference marker, the rest come from the frame
assign sel_idx = epoch ? 7'h00 : idx_r + 7'h01;

// byte-lane merge for wishbone writes
function [31:0] merge;
  input [31:0] old_v;
  input [31:0] new_v;
  input [3:0] sel;
  integer b;
  begin
    merge = old_v;
    for (b = 0; b < 4; b = b + 1)
      if (sel[b])
        merge[b*8 +: 8] = new_v[b*8 +: 8];
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// marker position masks: reference at 0, then every tenth from 9 (long) or only 24 (short)
genvar gi;
generate
  for (gi = 0; gi < 100; gi = gi + 1)
  begin : g_mark
    assign mark_long[gi] = (gi == 0) || ((gi % 10) == 9);
    assign mark_short[gi] = (gi == 0) || (gi == 24);
  end
endgenerate

////////////////////////////////////////////////////////////////////////////
// quality code from the software error estimate
always @*
begin
  if (!gps_locked_once_i)
    quality = `TC_Q_BAD;
  else if (errns_r < `TC_ERR_1US)
    quality = `TC_Q_1US;
  else if (errns_r < `TC_ERR_10US)
    quality = `TC_Q_10US;
  else if (errns_r < `TC_ERR_100US)
    quality = `TC_Q_100US;
  else if (errns_r < `TC_ERR_1MS)
    quality = `TC_Q_1MS;
  else if (errns_r < `TC_ERR_10MS)
    quality = `TC_Q_10MS;
  else
    quality = `TC_Q_BAD;
end

////////////////////////////////////////////////////////////////////////////
// frame content for the second about to start; markers are zero here
always @*
begin
  frame_nxt = 100'h0;
  if (fmt_wr == `TC_FMT_2137)
  begin
    frame_nxt[7:1] = time0_r[6:0];
    frame_nxt[14:8] = time0_r[14:8];
    frame_nxt[20:15] = time0_r[21:16];
  end
  else
  begin
    // BCD time of year, shared by the long formats
    frame_nxt[4:1] = time0_r[3:0];
    frame_nxt[8:6] = time0_r[6:4];
    frame_nxt[13:10] = time0_r[11:8];
    frame_nxt[17:15] = time0_r[14:12];
    frame_nxt[23:20] = time0_r[19:16];
    frame_nxt[26:25] = time0_r[21:20];
    frame_nxt[33:30] = time0_r[25:22];
    frame_nxt[38:35] = time0_r[29:26];
    frame_nxt[41:40] = time0_r[31:30];
    if (fmt_wr == `TC_FMT_B123 || fmt_wr == `TC_FMT_B120)
    begin
      frame_nxt[88:80] = time1_r[16:8];
      frame_nxt[97:90] = time1_r[24:17];
    end
    if (fmt_wr == `TC_FMT_B120)
    begin
      frame_nxt[53:50] = time1_r[3:0];
      frame_nxt[58:55] = time1_r[7:4];
      frame_nxt[60] = stcfg_r[`TC_ST_LEAP_PEND];
      frame_nxt[61] = stcfg_r[`TC_ST_LEAP_DEL];
      frame_nxt[62] = stcfg_r[`TC_ST_DST_PEND];
      frame_nxt[63] = stcfg_r[`TC_ST_DST_ACT];
      frame_nxt[64] = stcfg_r[`TC_ST_OFF_NEG];
      frame_nxt[68:65] = stcfg_r[`TC_ST_OFF_HR_LSB+3:`TC_ST_OFF_HR_LSB];
      frame_nxt[70] = stcfg_r[`TC_ST_OFF_HALF];
      frame_nxt[74:71] = quality;
      frame_nxt[75] = ~(^frame_nxt[74:0]);
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// symbol and pulse width of the element to be loaded next
always @*
begin
  if (sel_idx == 7'h00)
    sym = `TC_SYM_MARK;
  else if (short_fmt ? mark_short[sel_idx] : mark_long[sel_idx])
    sym = `TC_SYM_MARK;
  else if (frame_r[sel_idx])
    sym = `TC_SYM_ONE;
  else
    sym = `TC_SYM_ZERO;
  // on an epoch the format about to be latched sets the element period
  if ((epoch ? fmt_wr : fmt_r) == `TC_FMT_2137)
    period_wide = ELEM_CYC_SLOW;
  else
    period_wide = ELEM_CYC_FAST;
  case (sym)
    `TC_SYM_MARK: high_wide = period_wide / `TC_PCT_FULL * `TC_PCT_MARK;
    `TC_SYM_ONE: high_wide = period_wide / `TC_PCT_FULL * `TC_PCT_ONE;
    default: high_wide = period_wide / `TC_PCT_FULL * `TC_PCT_ZERO;
  endcase
end

////////////////////////////////////////////////////////////////////////////
// element timing
tc_element_shaper #(
  .CNT_W(CNT_W)
) u_shaper (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .ce_i(ce_i),
  .load_i(epoch),
  .more_i(more),
  .period_i(period_wide[CNT_W-1:0]),
  .high_i(high_wide[CNT_W-1:0]),
  .level_o(shp_level),
  .end_o(elem_end),
  .active_o(shp_active)
);

////////////////////////////////////////////////////////////////////////////
// frame sequencer; an epoch restarts the frame in any state
always @*
begin
  case (state_r)
    ST_IDLE: state_nxt = epoch ? ST_RUN : ST_IDLE;
    ST_RUN:
    begin
      if (epoch)
        state_nxt = ST_RUN;
      else if (!enable)
        state_nxt = ST_IDLE;
      else if (elem_end && !more)
        state_nxt = ST_WAIT;
      else
        state_nxt = ST_RUN;
    end
    ST_WAIT:
    begin
      if (epoch)
        state_nxt = ST_RUN;
      else if (!enable)
        state_nxt = ST_IDLE;
      else
        state_nxt = ST_WAIT;
    end
    default: state_nxt = ST_IDLE;
  endcase
end

always @(posedge clk_i)
begin
  if (rst_i)
  begin
    state_r <= ST_IDLE;
    idx_r <= 7'h00;
    fmt_r <= `TC_FMT_B122;
    frame_r <= 100'h0;
    frame_cnt_r <= 16'h0000;
  end
  else if (ce_i)
  begin
    state_r <= state_nxt;
    if (epoch)
    begin
      // format and content are frozen for the whole frame
      idx_r <= 7'h00;
      fmt_r <= fmt_wr;
      frame_r <= frame_nxt;
      frame_cnt_r <= frame_cnt_r + 16'h0001;
    end
    else if (elem_end && more)
      idx_r <= idx_r + 7'h01;
  end
end

////////////////////////////////////////////////////////////////////////////
// outputs: both forms carry the same envelope; the carrier is outside
always @(posedge clk_i)
begin
  if (rst_i)
  begin
    dc_level_shift_o <= 1'b0;
    modulated_timecode_output_o <= 1'b0;
    frame_active_o <= 1'b0;
  end
  else if (ce_i)
  begin
    dc_level_shift_o <= shp_level && ctrl_r[`TC_CTRL_DC_BIT] && enable;
    modulated_timecode_output_o <= shp_level && ctrl_r[`TC_CTRL_AM_BIT] && enable;
    frame_active_o <= shp_active && enable;
  end
end

////////////////////////////////////////////////////////////////////////////
// wishbone slave: ack one cycle after the request, unmapped reads zero
always @*
begin
  case (adr_i)
    `TC_REG_CTRL: rd_val = ctrl_r;
    `TC_REG_TIME0: rd_val = time0_r;
    `TC_REG_TIME1: rd_val = time1_r;
    `TC_REG_STCFG: rd_val = stcfg_r;
    `TC_REG_ERRNS: rd_val = errns_r;
    `TC_REG_STAT: rd_val = {frame_cnt_r, quality, state_r, 2'b00, idx_r};
    default: rd_val = 32'h00000000;
  endcase
end

always @(posedge clk_i)
begin
  if (rst_i)
  begin
    ack_o <= 1'b0;
    dat_o <= 32'h00000000;
    ctrl_r <= `TC_CTRL_RST;
    time0_r <= `TC_TIME0_RST;
    time1_r <= `TC_TIME1_RST;
    stcfg_r <= `TC_STCFG_RST;
    errns_r <= `TC_ERRNS_RST;
  end
  else if (ce_i)
  begin
    ack_o <= req;
    dat_o <= (req && !we_i) ? rd_val : 32'h00000000;
    if (req && we_i)
    begin
      case (adr_i)
        `TC_REG_CTRL: ctrl_r <= merge(ctrl_r, dat_i, sel_i) & 32'h0000003F;
        `TC_REG_TIME0: time0_r <= merge(time0_r, dat_i, sel_i);
        `TC_REG_TIME1: time1_r <= merge(time1_r, dat_i, sel_i) & 32'h01FFFFFF;
        `TC_REG_STCFG: stcfg_r <= merge(stcfg_r, dat_i, sel_i) & 32'h000003FF;
        `TC_REG_ERRNS: errns_r <= merge(errns_r, dat_i, sel_i);
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end
end

endmodule

/* File: irig_tc_defines.vh */
// constants for the serial timecode frame encoder: register map,
// field positions, reset values, formats, element timing and quality bands.
// assumes a 25 MHz system clock and a 32-bit classic wishbone slave port.
`ifndef IRIG_TC_DEFINES_VH
`define IRIG_TC_DEFINES_VH

////////////////////////////////////////////////////////////////////////////
// timing
`define TC_CLK_KHZ 25000
`define TC_ELEM_MS_FAST 10
`define TC_ELEM_MS_SLOW 40
`define TC_ELEM_CYC_FAST (`TC_ELEM_MS_FAST * `TC_CLK_KHZ)
`define TC_ELEM_CYC_SLOW (`TC_ELEM_MS_SLOW * `TC_CLK_KHZ)
`define TC_PCT_ZERO 20
`define TC_PCT_ONE 50
`define TC_PCT_MARK 80
`define TC_PCT_FULL 100

////////////////////////////////////////////////////////////////////////////
// frame formats and lengths
`define TC_FMT_B122 3'h0
`define TC_FMT_B123 3'h1
`define TC_FMT_B120 3'h2
`define TC_FMT_N36 3'h3
`define TC_FMT_2137 3'h4
`define TC_LAST_LONG 7'h63
`define TC_LAST_SHORT 7'h18

////////////////////////////////////////////////////////////////////////////
// element symbols
`define TC_SYM_ZERO 2'h0
`define TC_SYM_ONE 2'h1
`define TC_SYM_MARK 2'h2

////////////////////////////////////////////////////////////////////////////
// register word offsets (byte addresses)
`define TC_REG_CTRL 8'h00
`define TC_REG_TIME0 8'h04
`define TC_REG_TIME1 8'h08
`define TC_REG_STCFG 8'h0C
`define TC_REG_ERRNS 8'h10
`define TC_REG_STAT 8'h14

// control fields and register reset values
`define TC_CTRL_FMT_LSB 0
`define TC_CTRL_EN_BIT 3
`define TC_CTRL_DC_BIT 4
`define TC_CTRL_AM_BIT 5
`define TC_CTRL_RST 32'h00000038
`define TC_TIME0_RST 32'h00400000
`define TC_TIME1_RST 32'h00000000
`define TC_STCFG_RST 32'h00000000
`define TC_ERRNS_RST 32'hFFFFFFFF

// status-config fields
`define TC_ST_LEAP_PEND 0
`define TC_ST_LEAP_DEL 1
`define TC_ST_DST_PEND 2
`define TC_ST_DST_ACT 3
`define TC_ST_OFF_NEG 4
`define TC_ST_OFF_HR_LSB 5
`define TC_ST_OFF_HALF 9

////////////////////////////////////////////////////////////////////////////
// time error bands in ns and quality codes
`define TC_ERR_1US 32'h000003E8
`define TC_ERR_10US 32'h00002710
`define TC_ERR_100US 32'h000186A0
`define TC_ERR_1MS 32'h000F4240
`define TC_ERR_10MS 32'h00989680
`define TC_Q_1US 4'h4
`define TC_Q_10US 4'h5
`define TC_Q_100US 4'h6
`define TC_Q_1MS 4'h7
`define TC_Q_10MS 4'h8
`define TC_Q_BAD 4'h9

`endif

/* File: tc_element_shaper.v */
// one pulse-width coded timecode element: high for high_i cycles,
// low for the rest of period_i; reloads back to back while more_i is high.
// assumes high_i is at least 1 and below period_i.
`timescale 1ns/1ps
module tc_element_shaper #(
  parameter CNT_W = 24
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire load_i,
  input wire more_i,
  input wire [CNT_W-1:0] period_i,
  input wire [CNT_W-1:0] high_i,
  output reg level_o,
  output wire end_o,
  output reg active_o
);

reg [CNT_W-1:0] cnt_r;
reg [CNT_W-1:0] period_r;
reg [CNT_W-1:0] high_r;
wire [CNT_W-1:0] cnt_inc;

assign cnt_inc = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
// last cycle of the element; caller advances its index on this
assign end_o = active_o && (cnt_inc == period_r);

////////////////////////////////////////////////////////////////////////////
// counter: load restarts at once, so a resync never stretches an element
always @(posedge clk_i)
begin
  if (rst_i)
  begin
    cnt_r <= {CNT_W{1'b0}};
    period_r <= {CNT_W{1'b0}};
    high_r <= {CNT_W{1'b0}};
    level_o <= 1'b0;
    active_o <= 1'b0;
  end
  else if (ce_i)
  begin
    if (load_i || (end_o && more_i))
    begin
      cnt_r <= {CNT_W{1'b0}};
      period_r <= period_i;
      high_r <= high_i;
      level_o <= 1'b1; // every element opens with its rising edge
      active_o <= 1'b1;
    end
    else if (end_o)
    begin
      level_o <= 1'b0;
      active_o <= 1'b0;
    end
    else if (active_o)
    begin
      cnt_r <= cnt_inc;
      level_o <= (cnt_inc < high_r);
    end
  end
end

endmodule

/* File: tc_encoder_chk_sva.sv */
// port checker for the timecode encoder: bus handshake and element shapes
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
module tc_encoder_chk #(
  parameter ELEM_CYC_FAST = 100,
  parameter ELEM_CYC_SLOW = 400
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire epoch_i,
  input wire cyc_i,
  input wire stb_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire dc_level_shift_o,
  input wire frame_active_o
);
  localparam int MAXH = ELEM_CYC_SLOW * 4 / 5;
  localparam int MINH = ELEM_CYC_FAST / 5 - 2;
  reg [23:0] hcnt_r;
  //////////////////////////////////////////////////////////////////
  // run length of the pulse; two cycles of slack for sampling lag
  always @(posedge clk_i)
  begin
    if (rst_i || !dc_level_shift_o)
      hcnt_r <= 24'h000000;
    else if (ce_i)
      hcnt_r <= hcnt_r + 24'h000001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
    else $error("bus request not answered next cycle");
  chk_ack_single: assert property (ack_o && ce_i |=> !ack_o)
    else $error("ack held longer than one cycle");
  chk_dat_quiet: assert property (!ack_o |-> dat_o == 32'h00000000)
    else $error("read data outside ack cycle");
  chk_pulse_max: assert property (hcnt_r <= MAXH)
    else $error("element pulse too long");
  chk_pulse_min: assert property ($fell(dc_level_shift_o) |-> hcnt_r >= MINH)
    else $error("element pulse too short");
  chk_dc_in_frame: assert property (dc_level_shift_o |-> frame_active_o)
    else $error("level output high outside frame");
  chk_frame_start: assert property ($rose(frame_active_o) |-> $past(epoch_i, 2))
    else $error("frame started without epoch");
  chk_ce_frozen: assert property (!ce_i |=> $stable(ack_o) && $stable(frame_active_o))
    else $error("state moved with clock enable low");
endmodule
bind irig_timecode_frame_encoder tc_encoder_chk #(.ELEM_CYC_FAST(ELEM_CYC_FAST),
  .ELEM_CYC_SLOW(ELEM_CYC_SLOW)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .epoch_i(epoch_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
  .dc_level_shift_o(dc_level_shift_o), .frame_active_o(frame_active_o));

/* File: tc_reader_model.sv */
// timecode reader: measures each pulse on the level-shift line
// assumes period_i is the element length in clock cycles
`timescale 1ns/1ps
module tc_reader_model (
  input wire clk_i,
  input wire clr_i,
  input wire line_i,
  input wire [19:0] period_i
);
  reg [1:0] sym [0:99];
  integer cnt_r;
  integer hc_r;
  //////////////////////////////////////////////////////////////////
  // thresholds midway between nominal widths, tolerant of skew
  always @(posedge clk_i)
  begin
    if (clr_i)
    begin
      cnt_r <= 0;
      hc_r <= 0;
    end
    else if (line_i)
      hc_r <= hc_r + 1;
    else if (hc_r != 0)
    begin
      if (cnt_r < 100)
        sym[cnt_r] <= (hc_r * 100 < 35 * period_i) ? 2'h0 :
          (hc_r * 100 < 65 * period_i) ? 2'h1 : 2'h2;
      cnt_r <= cnt_r + 1;
      hc_r <= 0;
    end
  end
endmodule

/* File: testbench.sv */
// self-checking bench for the timecode encoder with a pulse-width reader
// assumes the reader model and the bound checker are compiled alongside
`timescale 1ns/1ps
`include "irig_tc_defines.vh"
`define CHK(a, e) begin total_checks = total_checks + 1; if ((a) !== (e)) begin \
  num_errors = num_errors + 1; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module testbench;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg ce_i = 1'b1;
  reg epoch_i = 1'b0;
  reg gps_locked_once_i = 1'b1;
  reg cyc_i = 1'b0;
  reg stb_i = 1'b0;
  reg we_i = 1'b0;
  reg [7:0] adr_i = 8'h00;
  reg [3:0] sel_i = 4'hF;
  reg [31:0] dat_i = 32'h00000000;
  reg clr_r = 1'b0;
  reg [19:0] per_r = 20'h00064;
  reg [31:0] seed_r = 32'h00013D39;
  reg [31:0] rd_r;
  wire [31:0] dat_o;
  wire ack_o;
  wire dc_level_shift_o;
  wire modulated_timecode_output_o;
  wire frame_active_o;
  integer num_errors = 0;
  integer total_checks = 0;
  irig_timecode_frame_encoder #(.ELEM_CYC_FAST(100), .ELEM_CYC_SLOW(400))
    u_irig_timecode_frame_encoder (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .epoch_i(epoch_i), .gps_locked_once_i(gps_locked_once_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .dc_level_shift_o(dc_level_shift_o),
    .modulated_timecode_output_o(modulated_timecode_output_o),
    .frame_active_o(frame_active_o));
  tc_reader_model u_tc_reader_model (.clk_i(clk_i), .clr_i(clr_r),
    .line_i(dc_level_shift_o), .period_i(per_r));
  //////////////////////////////////////////////////////////////////
  // 25 MHz clock and a generous cap on the whole run
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end
  initial
  begin
    #4000000;
    num_errors = num_errors + 1;
    results;
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [3:0] qual(input [31:0] e, input lk);
    qual = !lk ? `TC_Q_BAD : (e < `TC_ERR_1US) ? `TC_Q_1US : (e < `TC_ERR_10US) ? `TC_Q_10US :
      (e < `TC_ERR_100US) ? `TC_Q_100US : (e < `TC_ERR_1MS) ? `TC_Q_1MS :
      (e < `TC_ERR_10MS) ? `TC_Q_10MS : `TC_Q_BAD;
  endfunction
  function mk(input [2:0] f, input integer i);
    mk = (i == 0) || ((f == `TC_FMT_2137) ? (i == 24) : (i % 10 == 9));
  endfunction
  // expected data bits per element; markers carry a zero here
  function [99:0] exp_bits(input [2:0] f, input [31:0] t0, input [31:0] t1,
    input [31:0] st, input [3:0] q);
    reg [99:0] b;
    begin
      b = 100'h0;
      if (f == `TC_FMT_2137)
        b[20:1] = {t0[21:16], t0[14:8], t0[6:0]};
      else
        b[41:0] = {t0[31:30], 1'b0, t0[29:26], 1'b0, t0[25:22], 3'h0, t0[21:20], 1'b0,
          t0[19:16], 2'h0, t0[14:12], 1'b0, t0[11:8], 1'b0, t0[6:4], 1'b0, t0[3:0], 1'b0};
      if (f == `TC_FMT_B123 || f == `TC_FMT_B120)
        b[97:80] = {t1[24:17], 1'b0, t1[16:8]};
      if (f == `TC_FMT_B120)
        b[74:50] = {q, st[9], 1'b0, st[8:0], 1'b0, t1[7:4], 1'b0, t1[3:0]};
      if (f == `TC_FMT_B120)
        b[75] = ~^b[74:0];
      exp_bits = b;
    end
  endfunction
  // classic single cycle; released only at the edge that samples ack
  task wb(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i);
      #1;
      while (ack_o !== 1'b1)
      begin
        @(posedge clk_i);
        #1;
      end
      rd_r = dat_o;
      @(posedge clk_i);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
    end
  endtask
  // one frame with random contents, read back by the reader model
  task run_frame(input [2:0] f, input lk);
    reg [31:0] t0;
    reg [31:0] t1;
    reg [31:0] st;
    reg [99:0] b;
    reg [1:0] es;
    integer i;
    integer len;
    begin
      seed_r = lfsr(seed_r);
      t0 = seed_r;
      seed_r = lfsr(seed_r);
      t1 = seed_r & 32'h01FFFFFF;
      st = {22'h0, seed_r[31:22]};
      seed_r = lfsr(seed_r);
      len = (f == `TC_FMT_2137) ? 25 : 100;
      // inputs move only right after a rising edge
      @(posedge clk_i);
      gps_locked_once_i <= lk;
      per_r <= (f == `TC_FMT_2137) ? 20'h00190 : 20'h00064;
      wb(`TC_REG_TIME0, 1'b1, t0);
      wb(`TC_REG_TIME1, 1'b1, t1);
      wb(`TC_REG_STCFG, 1'b1, st);
      wb(`TC_REG_ERRNS, 1'b1, seed_r >> seed_r[4:0]);
      wb(`TC_REG_CTRL, 1'b1, {29'h7, f});
      clr_r <= 1'b1;
      epoch_i <= 1'b1;
      @(posedge clk_i);
      clr_r <= 1'b0;
      epoch_i <= 1'b0;
      #1;
      `CHK(dc_level_shift_o, 1'b0)
      @(posedge clk_i);
      #1;
      `CHK({dc_level_shift_o, modulated_timecode_output_o}, 2'h3)
      while (u_tc_reader_model.cnt_r < len)
        @(posedge clk_i);
      b = exp_bits(f, t0, t1, st, qual(seed_r >> seed_r[4:0], lk));
      for (i = 0; i < len; i = i + 1)
      begin
        es = mk(f, i) ? `TC_SYM_MARK : {1'b0, b[i]};
        `CHK(u_tc_reader_model.sym[i], es)
      end
      repeat (per_r) @(posedge clk_i);
      #1;
      `CHK(frame_active_o, 1'b0)
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////
  // reset values, unmapped access, clock-enable hold, then every format
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(`TC_REG_CTRL, 1'b0, 32'h00000000);
    `CHK(rd_r, `TC_CTRL_RST)
    wb(`TC_REG_TIME0, 1'b0, 32'h00000000);
    `CHK(rd_r, `TC_TIME0_RST)
    wb(`TC_REG_ERRNS, 1'b0, 32'h00000000);
    `CHK(rd_r, `TC_ERRNS_RST)
    wb(8'h20, 1'b1, 32'hFFFFFFFF);
    wb(8'h20, 1'b0, 32'h00000000);
    `CHK(rd_r, 32'h00000000)
    // single byte lane write: only lane 1 may land
    sel_i <= 4'h2;
    wb(`TC_REG_STCFG, 1'b1, 32'hFFFFFFFF);
    sel_i <= 4'hF;
    wb(`TC_REG_STCFG, 1'b0, 32'h00000000);
    `CHK(rd_r, 32'h00000300)
    ce_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    ce_i <= 1'b1;
    run_frame(`TC_FMT_B122, 1'b1);
    run_frame(`TC_FMT_B123, 1'b1);
    run_frame(`TC_FMT_B120, 1'b1);
    run_frame(`TC_FMT_B120, 1'b0);
    run_frame(`TC_FMT_N36, 1'b1);
    run_frame(`TC_FMT_2137, 1'b1);
    results;
  end
endmodule
